// [hw/mcs_column_shift.sv]
// Multiplier column shift control: operand read-in, stepping and transfer gating
// What this block does
// - Multiplier position counts read-in only when latched
// - Multiplicand latch set by brush, cleared by cancel
// - Units multiplier steps at 12 in sixth cycle
// - Positions two to six have own advance gates
// - Higher positions advance in successively earlier cycles
// - Multiplier positions are decade counters with carry
// - Units multiplier carry sets readout control latch
// - Ten phase-inverted roll pulses feed multiplicand positions
// - Output latch sets on carry, clears at 10
// - Set output latch opens its column shift gates
// - Zero digit carry at 10 is blocked
// - Stage one toggles on each running secondary carry except the one ending the sixth cycle
// - Stage two toggles when stage one turns off
// - Stage three sets after stage two; cancel clears
// - Timer decodes to six exclusive cycle selects
// - Sixth select drives units gate and half entry
// - End of sixth cycle clears run latch
//
// The APB slave port and the address map were decided locally.
`timescale 1ns/10ps
`include "mcs_defs.svh"

module mcs_column_shift
    import mcs_pkg::*;
(
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         ce,
    input  wire mcs_apb_req_t apb_req,
    output mcs_apb_rsp_t      apb_rsp,
    input  wire mcs_timing_t  timing,
    input  wire logic [5:0]   multiplier_brush,
    input  wire logic [5:0]   multiplicand_brush,
    output logic [10:0]       prod_pulse,
    output logic [5:0]        cycle_select,
    output logic              half_entry_control,
    output logic              computing
);

    // ************************************************************
    // State and decode
    // ************************************************************
    mcs_state_t  r;
    mcs_state_t  next_r;
    logic [5:0]  sel;
    logic [5:0]  mpr_inc;
    logic [5:0]  mpr_carry;
    logic [5:0]  mcd_inc;
    logic [5:0]  mcd_carry;
    logic [5:0][3:0] mpr_next;
    logic [5:0][3:0] mcd_next;
    logic [5:0][10:0] prod_contrib;
    logic [10:0] prod_hit;
    logic        apb_done;
    logic        wr;
    logic        start;
    logic        cancel;
    logic        last_carry;
    logic [31:0] rd_value;
    logic        rd_hit;

    function automatic logic [3:0] decade_bump(input logic [3:0] d);
        decade_bump = (d == `MCS_DIGIT_MAX) ? `MCS_DIGIT_RESET : d + 4'h1;
    endfunction

    // Select index is the multiplier position served: cycle k drives position 6-k
    always_comb
    begin
        sel = 6'h00;
        sel[5] = r.tertiary_stage_one & ~r.tertiary_stage_two & ~r.tertiary_stage_three;
        sel[4] = ~r.tertiary_stage_one & r.tertiary_stage_two & ~r.tertiary_stage_three;
        sel[3] = r.tertiary_stage_one & r.tertiary_stage_two & ~r.tertiary_stage_three;
        sel[2] = ~r.tertiary_stage_one & ~r.tertiary_stage_two & r.tertiary_stage_three;
        sel[1] = r.tertiary_stage_one & ~r.tertiary_stage_two & r.tertiary_stage_three;
        sel[0] = ~r.tertiary_stage_one & r.tertiary_stage_two & r.tertiary_stage_three;
    end

    // ************************************************************
    // Per-position counters and gates
    // ************************************************************
    genvar p;
    generate
        for (p = 0; p < `MCS_DIGITS; p = p + 1)
        begin : g_pos
            // Read-in gate or advance gate, each position with its own select
            assign mpr_inc[p] = (timing.readin_pulse & r.multiplier_readin_latch[p])
                | (timing.step_pulse & r.computation_run_latch & sel[p]);
            assign mpr_next[p] = decade_bump(r.multiplier_digit[p]);
            assign mpr_carry[p] = mpr_inc[p] & (r.multiplier_digit[p] == `MCS_DIGIT_MAX);
            // Roll pulses arrive one cycle late, in the opposite phase
            assign mcd_inc[p] = (timing.readin_pulse & r.multiplicand_readin_latch[p])
                | r.roll_phase;
            assign mcd_next[p] = decade_bump(r.multiplicand_digit[p]);
            assign mcd_carry[p] = r.roll_phase
                & (r.multiplicand_digit[p] == `MCS_DIGIT_MAX);
            // Output latch opens the gates to product positions p .. p+5
            assign prod_contrib[p] = r.multiplicand_output_latch[p]
                ? (11'(sel) << p) : 11'h000;
        end
    endgenerate

    always_comb
    begin
        prod_hit = 11'h000;
        for (int i = 0; i < `MCS_DIGITS; i++)
        begin
            prod_hit = prod_hit | prod_contrib[i];
        end
    end

    // ************************************************************
    // Register bus
    // ************************************************************
    assign apb_done = ce & apb_req.psel & apb_req.penable & r.captured;
    assign wr = apb_done & apb_req.pwrite;
    assign start = wr & (apb_req.paddr == `MCS_ADDR_CTRL)
        & apb_req.pwdata[`MCS_CTRL_START_BIT];
    assign cancel = wr & (apb_req.paddr == `MCS_ADDR_CTRL)
        & apb_req.pwdata[`MCS_CTRL_CANCEL_BIT];
    assign last_carry = timing.sec_carry & r.computation_run_latch & sel[0];

    always_comb
    begin
        rd_hit = 1'b1;
        case (apb_req.paddr)
            `MCS_ADDR_CTRL:
                rd_value = `MCS_RDATA_RESET;
            `MCS_ADDR_STATUS:
                rd_value = {3'h0, sel, r.computation_run_latch, r.tertiary_stage_three,
                    r.tertiary_stage_two, r.tertiary_stage_one,
                    r.multiplicand_readout_control_latch, r.multiplicand_output_latch,
                    r.multiplicand_readin_latch, r.multiplier_readin_latch};
            `MCS_ADDR_MULTIPLIER:
                rd_value = {8'h00, r.multiplier_digit};
            `MCS_ADDR_MULTIPLICAND:
                rd_value = {8'h00, r.multiplicand_digit};
            default:
            begin
                rd_value = `MCS_RDATA_RESET;
                rd_hit = 1'b0;
            end
        endcase
    end

    assign apb_rsp.pready = ce & r.captured;
    assign apb_rsp.prdata = r.prdata;
    assign apb_rsp.pslverr = r.pslverr;

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb
    begin
        next_r = r;
        next_r.captured = apb_req.psel & ~apb_done;
        if (apb_req.psel & ~r.captured)
        begin
            next_r.prdata = rd_value;
            next_r.pslverr = ~rd_hit;
        end
        next_r.multiplier_readin_latch = r.multiplier_readin_latch | multiplier_brush;
        next_r.multiplicand_readin_latch = r.multiplicand_readin_latch
            | multiplicand_brush;
        for (int i = 0; i < `MCS_DIGITS; i++)
        begin
            if (mpr_inc[i])
            begin
                next_r.multiplier_digit[i] = mpr_next[i];
            end
            if (mcd_inc[i])
            begin
                next_r.multiplicand_digit[i] = mcd_next[i];
            end
        end
        next_r.roll_phase = timing.roll_pulse & r.multiplicand_readout_control_latch
            & r.computation_run_latch;
        next_r.prod_pulse = r.roll_phase ? prod_hit : 11'h000;
        // Stop pulse wins over a carry in the same cycle
        next_r.multiplicand_output_latch = (r.multiplicand_output_latch | mcd_carry)
            & ~{6{timing.transfer_stop}};
        if (timing.sec_carry & r.computation_run_latch)
        begin
            next_r.multiplicand_readout_control_latch = 1'b0;
        end
        if (|mpr_carry)
        begin
            next_r.multiplicand_readout_control_latch = 1'b1;
        end
        if (start & ~r.computation_run_latch)
        begin
            next_r.computation_run_latch = 1'b1;
            next_r.tertiary_stage_one = 1'b0;
            next_r.tertiary_stage_two = 1'b0;
            next_r.tertiary_stage_three = 1'b0;
        end
        else if (last_carry)
        begin
            next_r.computation_run_latch = 1'b0;
        end
        else if (timing.sec_carry & r.computation_run_latch)
        begin
            next_r.tertiary_stage_one = ~r.tertiary_stage_one;
            if (r.tertiary_stage_one)
            begin
                next_r.tertiary_stage_two = ~r.tertiary_stage_two;
                if (r.tertiary_stage_two)
                begin
                    next_r.tertiary_stage_three = 1'b1;
                end
            end
        end
        if (cancel)
        begin
            next_r.multiplier_readin_latch = 6'h00;
            next_r.multiplicand_readin_latch = 6'h00;
            next_r.multiplier_digit = '0;
            next_r.multiplicand_digit = '0;
            next_r.multiplicand_output_latch = 6'h00;
            next_r.multiplicand_readout_control_latch = 1'b0;
            next_r.roll_phase = 1'b0;
            next_r.tertiary_stage_one = 1'b0;
            next_r.tertiary_stage_two = 1'b0;
            next_r.tertiary_stage_three = 1'b0;
            next_r.computation_run_latch = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            r <= '0;
        end
        else if (ce)
        begin
            r <= next_r;
        end
    end

    assign prod_pulse = r.prod_pulse;
    assign cycle_select = sel;
    assign half_entry_control = sel[0] & r.computation_run_latch;
    assign computing = r.computation_run_latch;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence seq_sixth_end;
        ce && last_carry && !cancel && !start;
    endsequence

    sequence seq_step_units;
        ce && r.computation_run_latch && timing.step_pulse && sel[0] && !cancel
            && !(timing.readin_pulse && r.multiplier_readin_latch[0]);
    endsequence

    AST_MPR_HOLD: assert property (
        ce && !cancel && !r.multiplier_readin_latch[0]
            && !(timing.step_pulse && r.computation_run_latch && sel[0])
            |=> $stable(r.multiplier_digit[0]))
        else $error("Multiplier units counted without its latch");

    AST_MCD_LATCH: assert property (
        r.multiplicand_readin_latch[0] && !cancel |=> r.multiplicand_readin_latch[0])
        else $error("Multiplicand latch lost without cancel");

    AST_UNITS_STEP: assert property (
        seq_step_units |=> r.multiplier_digit[0] == decade_bump($past(r.multiplier_digit[0])))
        else $error("Units multiplier did not step in sixth cycle");

    AST_NO_STEP_OFF: assert property (
        ce && !cancel && !sel[1] && !r.multiplier_readin_latch[1]
            |=> $stable(r.multiplier_digit[1]))
        else $error("Second multiplier position stepped outside fifth cycle");

    AST_READOUT_SET: assert property (
        ce && mpr_carry[0] && !cancel |=> r.multiplicand_readout_control_latch)
        else $error("Units carry did not set readout control");

    AST_STOP_CLEAR: assert property (
        ce && timing.transfer_stop |=> r.multiplicand_output_latch == 6'h00)
        else $error("Output latch set after stop pulse");

    AST_GATE_CAUSE: assert property (
        r.prod_pulse[0] |-> $past(r.multiplicand_output_latch[0]) && $past(sel[0]))
        else $error("Product pulse without open gate");

    AST_SEL_ONEHOT: assert property (
        $onehot0(sel))
        else $error("Cycle selects overlap");

    AST_TIMER_ADV: assert property (
        ce && timing.sec_carry && r.computation_run_latch && !cancel && !start
            && (sel[5:1] != 5'h00) |=> sel == ($past(sel) >> 1))
        else $error("Tertiary timer did not advance one cycle");

    AST_END: assert property (
        seq_sixth_end |=> !r.computation_run_latch ##1 !half_entry_control)
        else $error("Computation did not stop after sixth cycle");

    AST_START_CLR: assert property (
        ce && start && !cancel && !r.computation_run_latch
            |=> sel == 6'h00 && r.computation_run_latch)
        else $error("Timer not cleared at computation start");

    AST_READIN_COUNT: assert property (
        ce && !cancel && timing.readin_pulse && r.multiplier_readin_latch[1]
            |=> r.multiplier_digit[1] == decade_bump($past(r.multiplier_digit[1])))
        else $error("Multiplier read-in pulse not counted");

    AST_POS_STEP: assert property (
        ce && !cancel && timing.step_pulse && r.computation_run_latch && sel[4]
            |=> r.multiplier_digit[4] == decade_bump($past(r.multiplier_digit[4])))
        else $error("Fifth multiplier position did not step in its cycle");

    AST_WRAP: assert property (
        ce && !cancel && mpr_inc[2] && r.multiplier_digit[2] == `MCS_DIGIT_MAX
            |-> mpr_carry[2] ##1 r.multiplier_digit[2] == `MCS_DIGIT_RESET)
        else $error("Multiplier position did not wrap with carry");

    AST_READOUT_ANY: assert property (
        ce && mpr_carry[3] && !cancel |=> r.multiplicand_readout_control_latch)
        else $error("Position carry did not set readout control");

    AST_ROLL_STEP: assert property (
        ce && !cancel && r.roll_phase
            |=> r.multiplicand_digit[0] == decade_bump($past(r.multiplicand_digit[0])))
        else $error("Multiplicand did not roll on inverted pulse");

    AST_OUT_SET: assert property (
        ce && !cancel && mcd_carry[3] && !timing.transfer_stop
            |=> r.multiplicand_output_latch[3])
        else $error("Output latch not set on multiplicand carry");

    AST_STAGE_TWO: assert property (
        ce && !cancel && !start && timing.sec_carry && r.computation_run_latch
            && r.tertiary_stage_one
            |=> r.tertiary_stage_two != $past(r.tertiary_stage_two))
        else $error("Stage two did not toggle as stage one turned off");

    AST_STAGE_THREE: assert property (
        r.tertiary_stage_three && !cancel && !(ce && start && !r.computation_run_latch)
            |=> r.tertiary_stage_three)
        else $error("Stage three cleared without cancel");

endmodule

// [hw/mcs_defs.svh]
// Offsets, field positions, reset values and counts of the column shift control
`ifndef MCS_DEFS_SVH
`define MCS_DEFS_SVH

`define MCS_ADDR_CTRL        12'h000
`define MCS_ADDR_STATUS      12'h004
`define MCS_ADDR_MULTIPLIER  12'h008
`define MCS_ADDR_MULTIPLICAND 12'h00C

`define MCS_CTRL_START_BIT   0
`define MCS_CTRL_CANCEL_BIT  1

`define MCS_DIGITS           6
`define MCS_PROD_DIGITS      11
`define MCS_DIGIT_MAX        4'h9
`define MCS_DIGIT_RESET      4'h0
`define MCS_RDATA_RESET      32'h0000_0000

`endif

// [hw/mcs_pkg.sv]
// Types shared by the column shift control block
package mcs_pkg;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } mcs_apb_req_t;

    typedef struct packed {
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
    } mcs_apb_rsp_t;

    typedef struct packed {
        logic readin_pulse;
        logic step_pulse;
        logic roll_pulse;
        logic transfer_stop;
        logic sec_carry;
    } mcs_timing_t;

    typedef struct packed {
        logic [5:0]       multiplier_readin_latch;
        logic [5:0]       multiplicand_readin_latch;
        logic [5:0][3:0]  multiplier_digit;
        logic [5:0][3:0]  multiplicand_digit;
        logic [5:0]       multiplicand_output_latch;
        logic             multiplicand_readout_control_latch;
        logic             roll_phase;
        logic             tertiary_stage_one;
        logic             tertiary_stage_two;
        logic             tertiary_stage_three;
        logic             computation_run_latch;
        logic [10:0]      prod_pulse;
        logic             captured;
        logic [31:0]      prdata;
        logic             pslverr;
    } mcs_state_t;

endpackage

// [tb/mcs_card_model.sv]
// Partner model: card brushes, pulse timing and product pulse counters
`timescale 1ns/10ps

module mcs_card_model
    import mcs_pkg::*;
(
    input  wire logic [10:0] prod_pulse,
    input  wire logic        pclk,
    output mcs_timing_t      timing,
    output logic [5:0]       multiplier_brush,
    output logic [5:0]       multiplicand_brush
);
    // ****************************************
    // Pulse sources and product counter side
    // ****************************************
    localparam mcs_timing_t READIN = 5'h10;
    localparam mcs_timing_t STEP   = 5'h08;
    localparam mcs_timing_t ROLL   = 5'h04;
    localparam mcs_timing_t STOP   = 5'h02;
    localparam mcs_timing_t SEC    = 5'h01;
    int                     cnt [11];

    initial
    begin
        timing = '0;
        multiplier_brush = '0;
        multiplicand_brush = '0;
    end

    always @(posedge pclk)
    begin
        for (int i = 0; i < 11; i++)
        begin
            if (prod_pulse[i] === 1'b1)
                cnt[i]++;
        end
    end

    task automatic fire(input mcs_timing_t t, input bit gap = 1'b1);
        @(posedge pclk);
        timing <= t;
        if (gap)
        begin
            @(posedge pclk);
            timing <= '0;
        end
    endtask

    // A hole in row k is followed by k read-in pulses
    task automatic read_card(input logic [5:0][3:0] mr, input logic [5:0][3:0] md);
        for (int k = 9; k >= 1; k--)
        begin
            @(posedge pclk);
            for (int p = 0; p < 6; p++)
            begin
                multiplier_brush[p] <= (mr[p] == k);
                multiplicand_brush[p] <= (md[p] == k);
            end
            fire(READIN);
        end
        @(posedge pclk);
        multiplier_brush <= '0;
        multiplicand_brush <= '0;
    endtask

    // Ten rolls, stop on the edge after the tenth, then the step
    task automatic primary();
        for (int i = 0; i < 9; i++)
            fire(ROLL);
        fire(ROLL, 1'b0);
        fire(STOP);
        fire(STEP);
    endtask
endmodule

// [tb/tb_multiplier_column_shift_control.sv]
// Testbench: register access, card read-in and whole multiplications
`timescale 1ns/10ps
`include "mcs_defs.svh"

module tb_multiplier_column_shift_control
    import mcs_pkg::*;
();
    // ****************************************
    // Signals, clock and instances
    // ****************************************
    logic         pclk;
    logic         presetn;
    logic         ce;
    mcs_apb_req_t apb_req;
    mcs_apb_rsp_t apb_rsp;
    mcs_timing_t  timing;
    logic [5:0]   mr_brush;
    logic [5:0]   md_brush;
    logic [10:0]  prod_pulse;
    logic [5:0]   cycle_select;
    logic         half_entry_control;
    logic         computing;
    int           failures;
    int           compares;

    initial
    begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    mcs_column_shift dut (
        .pclk               (pclk),
        .presetn            (presetn),
        .ce                 (ce),
        .apb_req            (apb_req),
        .apb_rsp            (apb_rsp),
        .timing             (timing),
        .multiplier_brush   (mr_brush),
        .multiplicand_brush (md_brush),
        .prod_pulse         (prod_pulse),
        .cycle_select       (cycle_select),
        .half_entry_control (half_entry_control),
        .computing          (computing)
    );

    mcs_card_model u_card (
        .prod_pulse         (prod_pulse),
        .pclk               (pclk),
        .timing             (timing),
        .multiplier_brush   (mr_brush),
        .multiplicand_brush (md_brush)
    );

    // ****************************************
    // Tasks
    // ****************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        compares++;
        if (seen !== exp)
        begin
            failures++;
            $display("BAD %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n = 0;
        @(posedge pclk);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
        @(posedge pclk);
        apb_req.penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (apb_rsp.pready !== 1'b1 && n < 50);
        rd = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        check({31'h0, apb_rsp.pready !== 1'b1}, 32'h0, "pready wait");
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic eexp);
        logic [31:0] d;
        logic        e;
        apb(1'b0, a, 32'h0000_0000, d, e);
        check(d, exp, "read data");
        check({31'h0, e}, {31'h0, eexp}, "slave error");
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] wd);
        logic [31:0] d;
        logic        e;
        apb(1'b1, a, wd, d, e);
    endtask

    task automatic multiply(input logic [5:0][3:0] mr, input logic [5:0][3:0] md);
        logic [31:0] st;
        logic [31:0] d;
        logic        e;
        int          exp_cnt [11];
        st = 32'h0000_0000;
        for (int p = 0; p < 6; p++)
        begin
            st[p] = (mr[p] != 4'h0);
            st[p + 6] = (md[p] != 4'h0);
            for (int q = 0; q < 6; q++)
                exp_cnt[p + q] += md[p] * mr[q];
        end
        wr(`MCS_ADDR_CTRL, 32'h1 << `MCS_CTRL_CANCEL_BIT);
        for (int i = 0; i < 11; i++)
            u_card.cnt[i] = 0;
        u_card.read_card(mr, md);
        u_card.primary();
        rd_chk(`MCS_ADDR_MULTIPLIER, {8'h00, mr}, 1'b0);
        rd_chk(`MCS_ADDR_MULTIPLICAND, {8'h00, md}, 1'b0);
        rd_chk(`MCS_ADDR_STATUS, st, 1'b0);
        wr(`MCS_ADDR_CTRL, 32'h1 << `MCS_CTRL_START_BIT);
        @(negedge pclk);
        check({25'h0, computing, cycle_select}, 32'h40, "start");
        for (int n = 1; n <= 7; n++)
        begin
            u_card.fire(u_card.SEC);
            apb(1'b0, `MCS_ADDR_STATUS, 32'h0000_0000, d, e);
            if (n < 7)
            begin
                check({26'h0, cycle_select}, 32'h1 << (6 - n), "select");
                check({26'h0, d[28:23]}, 32'h1 << (6 - n), "select status");
                check({31'h0, half_entry_control}, 32'(n == 6), "half entry");
                check({29'h0, d[21:19]}, 32'(n), "tertiary stages");
                repeat (10) u_card.primary();
            end
        end
        check({31'h0, computing}, 32'h0, "stop");
        check(d & 32'h0007_FFFF, st, "latches after run");
        for (int i = 0; i < 11; i++)
            check(32'(u_card.cnt[i]), 32'(exp_cnt[i]), "product pulses");
        rd_chk(`MCS_ADDR_MULTIPLIER, {8'h00, mr}, 1'b0);
        rd_chk(`MCS_ADDR_MULTIPLICAND, {8'h00, md}, 1'b0);
    endtask

    // ****************************************
    // Main sequence and watchdog
    // ****************************************
    initial
    begin
        presetn = 1'b0;
        ce = 1'b1;
        apb_req = '0;
        failures = 0;
        compares = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(12'h010, 32'h0000_0000, 1'b1);
        wr(12'h010, 32'hFFFF_FFFF);
        rd_chk(`MCS_ADDR_STATUS, `MCS_RDATA_RESET, 1'b0);
        rd_chk(`MCS_ADDR_CTRL, 32'h0000_0000, 1'b0);
        multiply(24'h51_7309, 24'h64_9028);
        multiply(24'h99_9999, 24'h90_9090);
        wr(`MCS_ADDR_CTRL, 32'h1 << `MCS_CTRL_START_BIT);
        ce <= 1'b0;
        u_card.fire(u_card.SEC);
        ce <= 1'b1;
        @(negedge pclk);
        check({25'h0, computing, cycle_select}, 32'h40, "frozen by clock enable");
        repeat (4) u_card.fire(u_card.SEC);
        wr(`MCS_ADDR_CTRL, 32'h1 << `MCS_CTRL_CANCEL_BIT);
        @(negedge pclk);
        check({25'h0, computing, cycle_select}, 32'h0, "cancel");
        rd_chk(`MCS_ADDR_STATUS, 32'h0000_0000, 1'b0);
        rd_chk(`MCS_ADDR_MULTIPLIER, 32'h0000_0000, 1'b0);
        summarize();
    end

    initial
    begin
        repeat (20000) @(posedge pclk);
        failures++;
        summarize();
    end
endmodule
